// [verilog/gmii_port_consts.svh]
// Shared constants of the client-side GMII port: speed codes,
// replication counts and the transmit buffer shape.
// Assumes inclusion by bare name from design files only.
`ifndef GMII_PORT_CONSTS_SVH
`define GMII_PORT_CONSTS_SVH

// Speed select codes on i_speed
`define SPEED_10M           2'h0
`define SPEED_100M          2'h1
`define SPEED_1G            2'h2

// Clock periods each receive byte is held, per speed
`define REP_COUNT_1G        7'h01
`define REP_COUNT_100M      7'h0A
`define REP_COUNT_10M       7'h64

// Transmit elastic buffer shape
`define TX_FIFO_DEPTH       8
`define TX_WORD_WIDTH       10

// Reset values of the outputs
`define RX_DATA_RESET       8'h00
`define TX_DATA_RESET       8'h00

`endif

// [verilog/gmii_port_pkg.sv]
// Types of the client-side GMII port.
// Assumes the constants header is compiled alongside.
package gmii_port_pkg;

	// Transmit drain position relative to frames
	typedef enum logic [1:0] {
		TX_GAP   = 2'b01,
		TX_FRAME = 2'b10
	} tx_state_t;

endpackage

// [verilog/tx_elastic_fifo.sv]
// Synchronous FIFO used as the transmit elastic buffer.
// Assumes one clock, a shared clock enable and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module tx_elastic_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_resetn,
	input  wire logic             i_clock_en,
	// Fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Drain side
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);

	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("tx_elastic_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0]      wr_ptr_ff;
	logic [AW:0]      rd_ptr_ff;
	logic [AW:0]      nxt_wr_ptr;
	logic [AW:0]      nxt_rd_ptr;
	logic             push;
	logic             pop;

	// Extra pointer bit separates full from empty
	assign o_in_ready  = (wr_ptr_ff - rd_ptr_ff) != (AW+1)'(DEPTH);
	assign o_out_valid = wr_ptr_ff != rd_ptr_ff;
	assign o_out_data  = mem_ff[rd_ptr_ff[AW-1:0]];

	always_comb begin
		push       = i_in_valid && o_in_ready;
		pop        = i_out_ready && o_out_valid;
		nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
		nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else if (i_clock_en) begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
		end
	end

	// Storage carries no reset; only pointers need a defined value
	always_ff @(posedge i_clock) begin
		if (i_clock_en && push)
			mem_ff[wr_ptr_ff[AW-1:0]] <= i_in_data;
	end

endmodule
`default_nettype wire

// [verilog/sgmii_gmii_client_port.sv]
// Client-side GMII port of an SGMII physical coding sublayer.
// Assumes i_clock is the internal reference clock; the client's transmit
// clock is slow enough to be sampled by it (at least four samples per period).
`timescale 1ns/1ps
`default_nettype none
`include "gmii_port_consts.svh"

// Notes on behaviour
// [R1] Data paths identical to the 1000BASE-X build; only management differs.
// [R2] At 1 Gbps transmit client signals keep 1000BASE-X timing and meaning.
// [R3] At 100 Mbps client repeats each transmit byte for 10 clocks.
// [R4] At 10 Mbps client holds each transmit byte for 100 clocks.
// [R5] Client keeps interframe gaps legal; the port enforces none.
// [R6] At 1 Gbps receive outputs keep 1000BASE-X timing and encodings.
// [R7] At 100 Mbps each received byte is repeated for 10 clocks.
// [R8] At 10 Mbps each received byte is repeated for 100 clocks.
// [R9] Client samples each replicated receive byte once per repetition group.
// [R10] Transmit inputs cross an elastic buffer onto the internal reference clock.
// [R11] Transmit data and control are captured in input registers on transmit clock; here on i_clock, once per sampled transmit clock fall.
// [R12] Receive data and control leave through output registers.
// [R13] Receive clock forwarded through a double-data-rate output register.
// [R14] Forwarded receive clock is inverted, rising mid receive data window.
// [R15] All receive logic runs on the single internal reference clock.
// [R16] No frame fields interpreted; every byte under enable passes as data.
// [R17] Buffer adds or drops only idles, and flags overflow or underflow; here a full buffer loses frame bytes and a starved frame gets error words.
// [R18] Both parties agree on speed so replication factors match.
module sgmii_gmii_client_port #(
	parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
	// Clock, reset, enable
	input  wire logic       i_clock,
	input  wire logic       i_resetn,
	input  wire logic       i_clock_en,
	// Speed
	input  wire logic [1:0] i_speed,
	// Client transmit GMII
	input  wire logic       i_gmii_tx_clk,
	input  wire logic [7:0] i_gmii_txd,
	input  wire logic       i_gmii_tx_en,
	input  wire logic       i_gmii_tx_er,
	// Transmit towards the coding sublayer
	output logic      [7:0] o_pcs_txd,
	output logic            o_pcs_tx_en,
	output logic            o_pcs_tx_er,
	input  wire logic       i_pcs_tx_ready,
	// Transmit buffer errors
	output logic            o_tx_overflow,
	output logic            o_tx_underflow,
	// Receive from the coding sublayer
	input  wire logic [7:0] i_pcs_rxd,
	input  wire logic       i_pcs_rx_dv,
	input  wire logic       i_pcs_rx_er,
	input  wire logic       i_pcs_rx_valid,
	output logic            o_pcs_rx_ready,
	// Client receive GMII
	output logic      [7:0] o_gmii_rxd,
	output logic            o_gmii_rx_dv,
	output logic            o_gmii_rx_er,
	output logic            o_gmii_rx_clk
);

	localparam int W = `TX_WORD_WIDTH;

	initial begin
		if (FIFO_DEPTH < 4)
			$error("sgmii_gmii_client_port: FIFO_DEPTH below 4 cannot absorb a frame start");
	end

	// Clock periods per receive byte at the chosen speed
	function automatic logic [6:0] rep_count(input logic [1:0] speed);
		if (speed == `SPEED_1G)
			return `REP_COUNT_1G;
		else if (speed == `SPEED_100M)
			return `REP_COUNT_100M;
		else
			return `REP_COUNT_10M;
	endfunction

	// Transmit pin synchronisers
	logic [W:0]   sync1_ff;
	logic [W:0]   sync2_ff;
	logic         txclk_prev_ff;
	logic [W:0]   nxt_sync1;
	logic [W:0]   nxt_sync2;
	logic         nxt_txclk_prev;
	logic         tx_fall;

	always_comb begin
		nxt_sync1      = {i_gmii_tx_clk, i_gmii_tx_er, i_gmii_tx_en, i_gmii_txd};
		nxt_sync2      = sync1_ff;
		nxt_txclk_prev = sync2_ff[W];
		// Mid-period sample: data was launched on the rising edge
		tx_fall        = txclk_prev_ff && !sync2_ff[W];
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			sync1_ff      <= '0;
			sync2_ff      <= '0;
			txclk_prev_ff <= 1'b0;
		end else if (i_clock_en) begin
			sync1_ff      <= nxt_sync1;
			sync2_ff      <= nxt_sync2;
			txclk_prev_ff <= nxt_txclk_prev;
		end
	end

	// Input registers, loaded once per transmit clock period
	logic [W-1:0] cap_word_ff;
	logic         cap_strobe_ff;
	logic [W-1:0] nxt_cap_word;
	logic         nxt_cap_strobe;

	always_comb begin
		nxt_cap_word   = cap_word_ff;
		nxt_cap_strobe = tx_fall;
		if (tx_fall)
			nxt_cap_word = sync2_ff[W-1:0]; // [R11] [R2] [R3] [R4]
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			cap_word_ff   <= '0;
			cap_strobe_ff <= 1'b0;
		end else if (i_clock_en) begin
			cap_word_ff   <= nxt_cap_word;
			cap_strobe_ff <= nxt_cap_strobe;
		end
	end

	// Elastic buffer onto the reference clock
	logic         fifo_in_ready;
	logic         fifo_out_valid;
	logic [W-1:0] fifo_out_data;
	logic         fifo_pop;

	assign fifo_pop = i_pcs_tx_ready;

	tx_elastic_fifo #(
		.WIDTH (W),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.i_clock     (i_clock),
		.i_resetn    (i_resetn),
		.i_clock_en  (i_clock_en),
		.i_in_valid  (cap_strobe_ff), // [R10]
		.i_in_data   (cap_word_ff),
		.o_in_ready  (fifo_in_ready),
		.o_out_valid (fifo_out_valid),
		.o_out_data  (fifo_out_data),
		.i_out_ready (fifo_pop)
	);

	// Transmit drain and buffer error flags
	gmii_port_pkg::tx_state_t tx_state_ff;
	gmii_port_pkg::tx_state_t nxt_tx_state;
	logic [7:0]   txd_ff;
	logic         tx_en_ff;
	logic         tx_er_ff;
	logic         ovf_ff;
	logic         unf_ff;
	logic [7:0]   nxt_txd;
	logic         nxt_tx_en;
	logic         nxt_tx_er;
	logic         nxt_ovf;
	logic         nxt_unf;

	always_comb begin
		nxt_tx_state = tx_state_ff;
		nxt_txd      = txd_ff;
		nxt_tx_en    = tx_en_ff;
		nxt_tx_er    = tx_er_ff;
		// Full buffer: an idle is dropped silently, a frame byte is lost
		nxt_ovf      = cap_strobe_ff && !fifo_in_ready && cap_word_ff[8]; // [R17]
		nxt_unf      = 1'b0;
		if (i_pcs_tx_ready) begin
			case (tx_state_ff)
				gmii_port_pkg::TX_GAP: begin
					if (fifo_out_valid) begin
						// Bytes pass untouched, whatever field they belong to
						{nxt_tx_er, nxt_tx_en, nxt_txd} = fifo_out_data; // [R16] [R1]
						if (fifo_out_data[8])
							nxt_tx_state = gmii_port_pkg::TX_FRAME;
					end else begin
						// Idle inserted only between frames
						nxt_txd   = `TX_DATA_RESET; // [R17]
						nxt_tx_en = 1'b0;
						nxt_tx_er = 1'b0;
					end
				end
				gmii_port_pkg::TX_FRAME: begin
					if (fifo_out_valid) begin
						{nxt_tx_er, nxt_tx_en, nxt_txd} = fifo_out_data; // [R16]
						if (!fifo_out_data[8])
							nxt_tx_state = gmii_port_pkg::TX_GAP;
					end else begin
						// Starved mid-frame: corrupt rather than stretch silently
						nxt_txd   = `TX_DATA_RESET; // [R17]
						nxt_tx_en = 1'b1;
						nxt_tx_er = 1'b1;
						nxt_unf   = 1'b1;
					end
				end
				default: begin
					nxt_tx_state = gmii_port_pkg::TX_GAP;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			tx_state_ff <= gmii_port_pkg::TX_GAP;
			txd_ff      <= `TX_DATA_RESET;
			tx_en_ff    <= 1'b0;
			tx_er_ff    <= 1'b0;
			ovf_ff      <= 1'b0;
			unf_ff      <= 1'b0;
		end else if (i_clock_en) begin
			tx_state_ff <= nxt_tx_state;
			txd_ff      <= nxt_txd;
			tx_en_ff    <= nxt_tx_en;
			tx_er_ff    <= nxt_tx_er;
			ovf_ff      <= nxt_ovf;
			unf_ff      <= nxt_unf;
		end
	end

	assign o_pcs_txd      = txd_ff;
	assign o_pcs_tx_en    = tx_en_ff;
	assign o_pcs_tx_er    = tx_er_ff;
	assign o_tx_overflow  = ovf_ff;
	assign o_tx_underflow = unf_ff;

	// Receive replication, all on the reference clock
	logic [6:0]   rep_left_ff;
	logic [7:0]   rxd_ff;
	logic         rx_dv_ff;
	logic         rx_er_ff;
	logic [6:0]   nxt_rep_left;
	logic [7:0]   nxt_rxd;
	logic         nxt_rx_dv;
	logic         nxt_rx_er;
	logic         rep_done;

	always_comb begin
		rep_done     = rep_left_ff == 7'h00;
		nxt_rep_left = rep_left_ff;
		nxt_rxd      = rxd_ff;
		nxt_rx_dv    = rx_dv_ff;
		nxt_rx_er    = rx_er_ff;
		if (!rep_done) begin
			nxt_rep_left = rep_left_ff - 7'h01; // [R7] [R8]
		end else if (i_pcs_rx_valid) begin
			// Speed change lands on a byte boundary only
			nxt_rxd      = i_pcs_rxd; // [R6] [R15]
			nxt_rx_dv    = i_pcs_rx_dv;
			nxt_rx_er    = i_pcs_rx_er;
			nxt_rep_left = rep_count(i_speed) - 7'h01; // [R7] [R8] [R18]
		end else begin
			nxt_rxd      = `RX_DATA_RESET;
			nxt_rx_dv    = 1'b0;
			nxt_rx_er    = 1'b0;
		end
	end

	assign o_pcs_rx_ready = rep_done && i_clock_en;

	// Output registers sit directly at the receive pins
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			rep_left_ff <= 7'h00;
			rxd_ff      <= `RX_DATA_RESET;
			rx_dv_ff    <= 1'b0;
			rx_er_ff    <= 1'b0;
		end else if (i_clock_en) begin
			rep_left_ff <= nxt_rep_left;
			rxd_ff      <= nxt_rxd; // [R12]
			rx_dv_ff    <= nxt_rx_dv;
			rx_er_ff    <= nxt_rx_er;
		end
	end

	assign o_gmii_rxd   = rxd_ff;
	assign o_gmii_rx_dv = rx_dv_ff;
	assign o_gmii_rx_er = rx_er_ff;

	// Forwarded clock: two-phase output register, high phase follows clock low
	logic ddr_hi_ff;
	logic ddr_lo_ff;
	logic nxt_ddr_hi;
	logic nxt_ddr_lo;

	always_comb begin
		nxt_ddr_hi = 1'b0; // [R14]
		nxt_ddr_lo = 1'b1; // [R14]
	end

	// Same register stage as the data, so both see the same delay
	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			ddr_hi_ff <= 1'b0;
			ddr_lo_ff <= 1'b0;
		end else if (i_clock_en) begin
			ddr_hi_ff <= nxt_ddr_hi; // [R13] [R15]
			ddr_lo_ff <= nxt_ddr_lo;
		end
	end

	// Held low through reset and until the first enabled clock; keeps toggling while the enable is low
	assign o_gmii_rx_clk = i_clock ? ddr_hi_ff : ddr_lo_ff; // [R13]

endmodule
`default_nettype wire

// [bench/gmii_port_assertions.sv]
// Checker on the client port's pins, bound into the port module.
// Assumes i_clock_en is held high by the bench.
`timescale 1ns/1ps
`default_nettype none
module gmii_port_checker (
	input wire logic       i_clock,
	input wire logic       i_resetn,
	input wire logic [1:0] i_speed,
	input wire logic [7:0] i_pcs_rxd,
	input wire logic       i_pcs_rx_dv,
	input wire logic       i_pcs_rx_er,
	input wire logic       i_pcs_rx_valid,
	input wire logic       o_pcs_rx_ready,
	input wire logic [7:0] o_gmii_rxd,
	input wire logic       o_gmii_rx_dv,
	input wire logic       o_gmii_rx_er,
	input wire logic       o_gmii_rx_clk,
	input wire logic       i_pcs_tx_ready,
	input wire logic [7:0] o_pcs_txd,
	input wire logic       o_pcs_tx_en,
	input wire logic       o_pcs_tx_er
);
	logic take;
	assign take = i_pcs_rx_valid && o_pcs_rx_ready;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	chk_rxclk_high: assert property ($past(i_resetn) |-> o_gmii_rx_clk)
		else $error("forwarded clock low before rising edge");
	chk_rxclk_low: assert property (@(negedge i_clock) $past(i_resetn) |-> !o_gmii_rx_clk)
		else $error("forwarded clock high before falling edge");
	chk_rx_data: assert property (take |=>
		{o_gmii_rx_dv, o_gmii_rx_er, o_gmii_rxd} == $past({i_pcs_rx_dv, i_pcs_rx_er, i_pcs_rxd}))
		else $error("receive byte not passed");
	chk_rx_idle: assert property (o_pcs_rx_ready && !i_pcs_rx_valid |=>
		{o_gmii_rx_dv, o_gmii_rx_er, o_gmii_rxd} == 10'h000)
		else $error("receive outputs not idle");
	chk_rx_gig: assert property (take && i_speed == 2'h2 |=> o_pcs_rx_ready)
		else $error("gigabit byte held too long");
	chk_rx_ready_100: assert property (take && i_speed == 2'h1 |=>
		!o_pcs_rx_ready [*8] ##1 !o_pcs_rx_ready ##1 o_pcs_rx_ready)
		else $error("100M repetition count wrong");
	chk_rx_hold_100: assert property (take && i_speed == 2'h1 |=> ##1
		$stable({o_gmii_rx_dv, o_gmii_rx_er, o_gmii_rxd}) [*8] ##1
		$stable({o_gmii_rx_dv, o_gmii_rx_er, o_gmii_rxd}))
		else $error("100M byte not held");
	chk_rx_ready_10: assert property (take && i_speed != 2'h1 && i_speed != 2'h2 |=>
		!o_pcs_rx_ready [*8] ##91 !o_pcs_rx_ready ##1 o_pcs_rx_ready)
		else $error("10M repetition count wrong");
	chk_tx_hold: assert property (!i_pcs_tx_ready |=> $stable({o_pcs_txd, o_pcs_tx_en, o_pcs_tx_er}))
		else $error("transmit word moved without ready");
	chk_reset_quiet: assert property ($rose(i_resetn) |-> !o_gmii_rx_dv && !o_pcs_tx_en)
		else $error("outputs active out of reset");
endmodule
bind sgmii_gmii_client_port gmii_port_checker chk (.i_clock, .i_resetn, .i_speed, .i_pcs_rxd,
	.i_pcs_rx_dv, .i_pcs_rx_er, .i_pcs_rx_valid, .o_pcs_rx_ready, .o_gmii_rxd, .o_gmii_rx_dv,
	.o_gmii_rx_er, .o_gmii_rx_clk, .i_pcs_tx_ready, .o_pcs_txd, .o_pcs_tx_en, .o_pcs_tx_er);
`default_nettype wire

// [bench/gmii_client_model.sv]
// Client MAC model: free-running transmit clock and a word queue.
// Assumes the bench fills q with {en, er, txd}, already replicated.
`timescale 1ns/1ps
`default_nettype none
module gmii_client_model (
	// Transmit GMII
	output logic       o_tx_clk,
	output logic [7:0] o_txd,
	output logic       o_tx_en,
	output logic       o_tx_er
);
	logic [9:0] q[$];
	logic [9:0] w;
	initial begin
		o_tx_clk = 1'b0;
		{o_tx_en, o_tx_er, o_txd} = 10'h000;
		#37;
		forever #200 o_tx_clk = ~o_tx_clk;
	end
	// One word per period; idle when nothing queued keeps the gap
	always @(posedge o_tx_clk) begin
		w = q.size() ? q.pop_front() : 10'h000;
		{o_tx_en, o_tx_er, o_txd} <= w;
	end
endmodule
`default_nettype wire

// [bench/tb_sgmii_gmii_client_port.sv]
// Bench for the client port: replicated transmit frames, receive bytes.
// Assumes the checker is bound to the port.
`timescale 1ns/1ps
`default_nettype none
module tb_sgmii_gmii_client_port;
	logic        i_clock, i_resetn, i_gmii_tx_clk, i_gmii_tx_en, i_gmii_tx_er;
	logic [1:0]  i_speed;
	logic [7:0]  i_gmii_txd, o_pcs_txd, i_pcs_rxd, o_gmii_rxd;
	logic        o_pcs_tx_en, o_pcs_tx_er, i_pcs_tx_ready, o_tx_overflow, o_tx_underflow;
	logic        i_pcs_rx_dv, i_pcs_rx_er, i_pcs_rx_valid, o_pcs_rx_ready;
	logic        o_gmii_rx_dv, o_gmii_rx_er, o_gmii_rx_clk, hold, rdy_d;
	logic [9:0]  tq[$];
	logic [16:0] rq[$];
	logic [16:0] cur;
	logic [1:0]  spd[4] = '{2'h2, 2'h1, 2'h0, 2'h3};
	int          error_cnt, total_checks, rem, ufw, ufp, ovp;
	sgmii_gmii_client_port dut (.i_clock, .i_resetn, .i_clock_en(1'b1), .i_speed, .i_gmii_tx_clk,
		.i_gmii_txd, .i_gmii_tx_en, .i_gmii_tx_er, .o_pcs_txd, .o_pcs_tx_en, .o_pcs_tx_er,
		.i_pcs_tx_ready, .o_tx_overflow, .o_tx_underflow, .i_pcs_rxd, .i_pcs_rx_dv,
		.i_pcs_rx_er, .i_pcs_rx_valid, .o_pcs_rx_ready, .o_gmii_rxd, .o_gmii_rx_dv,
		.o_gmii_rx_er, .o_gmii_rx_clk);
	gmii_client_model cm (.o_tx_clk(i_gmii_tx_clk), .o_txd(i_gmii_txd), .o_tx_en(i_gmii_tx_en),
		.o_tx_er(i_gmii_tx_er));
	task automatic cmp_word(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_cnt(input int got, input int exp);
		cmp_word(10'(got), 10'(exp));
	endtask
	task automatic give_verdict;
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	function automatic logic [6:0] rep_of(input logic [1:0] s);
		return (s == 2'h2) ? 7'h01 : (s == 2'h1) ? 7'h0A : 7'h64;
	endfunction
	// Nonzero data keeps frame bytes apart from underflow fill words
	task automatic tx_frame(input int n, input int rep);
		logic [9:0] w;
		repeat (12) cm.q.push_back(10'h000);
		repeat (n) begin
			w = {2'b10, 8'($urandom) | 8'h01};
			w[8] = ($urandom % 8 == 0);
			repeat (rep) begin
				cm.q.push_back(w);
				tq.push_back(w);
			end
		end
		cm.q.push_back(10'h000);
		wait (cm.q.size() == 0);
	endtask
	task automatic rx_send(input logic [7:0] b, input logic [1:0] f);
		i_pcs_rxd = b;
		{i_pcs_rx_dv, i_pcs_rx_er} = f;
		i_pcs_rx_valid = 1'b1;
		@(negedge i_clock);
		while (!o_pcs_rx_ready) @(negedge i_clock);
		@(posedge i_clock);
		#1 rq.push_back({rep_of(i_speed), f, b});
	endtask
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		rdy_d <= i_pcs_tx_ready;
		#1 i_pcs_tx_ready = !hold && ($urandom % 4 != 0);
	end
	// Result watcher: one receive sample per repetition step
	always @(negedge i_clock) if (i_resetn) begin
		ufp += o_tx_underflow;
		ovp += o_tx_overflow;
		if (rdy_d && o_pcs_tx_en) begin
			if (o_pcs_tx_er && o_pcs_txd == 8'h00)
				ufw++;
			else
				cmp_word({o_pcs_tx_en, o_pcs_tx_er, o_pcs_txd}, tq.size() ? tq.pop_front() : 10'h000);
		end
		if (rem == 0) begin
			cur = rq.size() ? rq.pop_front() : 17'h0_0400;
			rem = cur[16:10];
		end
		cmp_word({o_gmii_rx_dv, o_gmii_rx_er, o_gmii_rxd}, cur[9:0]);
		rem--;
	end
	initial begin
		#3_000_000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		{i_resetn, hold, rdy_d, i_pcs_tx_ready, i_pcs_rx_valid, i_pcs_rx_dv, i_pcs_rx_er} = 7'h00;
		{i_speed, i_pcs_rxd} = 10'h200;
		void'($urandom(45));
		repeat (16) @(posedge i_clock);
		#1 i_resetn = 1'b1;
		foreach (spd[k]) begin
			i_speed = spd[k];
			fork
				tx_frame(4, rep_of(spd[k]));
				begin
					// Valid drops at once, or the last byte would be taken again
					for (int j = 0; j < 6; j++) begin
						rx_send(8'($urandom), 2'($urandom));
						if ($urandom % 2) begin
							i_pcs_rx_valid = 1'b0;
							@(posedge i_clock);
							#1;
						end
					end
					i_pcs_rx_valid = 1'b0;
				end
			join
			@(posedge i_clock);
			#1;
		end
		wait (tq.size() == 0);
		hold = 1'b1;
		tx_frame(14, 1);
		hold = 1'b0;
		repeat (100) @(posedge i_clock);
		cmp_cnt(tq.size(), ovp);
		cmp_cnt(ufw, ufp);
		give_verdict();
	end
endmodule
`default_nettype wire
